// ===== common/dmagc_pkg.sv
// Shared constants, register map and the write-alias function of the DMA control block
package dmagc_pkg;

    // ------------------------------------------------------------
    // Bus and field widths
    // ------------------------------------------------------------
    localparam int ADDR_W  = 16;
    localparam int PTR_W   = 16;
    localparam int PLAIN_N = 7;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [15:0] OFF_GLOBAL_CONTROL   = 16'h3000;
    localparam logic [15:0] OFF_CH2_CELL_PTR     = 16'h3280;
    localparam logic [15:0] OFF_CH2_PATTERN      = 16'h3290;
    localparam logic [15:0] OFF_CH3_CONTROL      = 16'h32A0;
    localparam logic [15:0] OFF_CH3_EVENT_CTRL   = 16'h32B0;
    localparam logic [15:0] OFF_CH3_INT_CTRL     = 16'h32C0;
    localparam logic [15:0] OFF_CH3_SRC_START    = 16'h32D0;
    localparam logic [15:0] OFF_CH3_DST_START    = 16'h32E0;
    localparam logic [15:0] OFF_CH3_SRC_SIZE     = 16'h32F0;
    localparam logic [15:0] OFF_CH3_DST_SIZE     = 16'h3300;
    localparam logic [15:0] OFF_CH3_SRC_PTR      = 16'h3310;
    localparam logic [15:0] OFF_CH3_DST_PTR      = 16'h3320;
    localparam logic [15:0] OFF_CH3_CELL_SIZE    = 16'h3330;
    localparam logic [15:0] OFF_CH3_CELL_PTR     = 16'h3340;
    localparam logic [15:0] OFF_CH3_PATTERN      = 16'h3350;

    // ------------------------------------------------------------
    // Alias kinds, taken from address bits 3:2
    // ------------------------------------------------------------
    localparam logic [1:0] ALIAS_WRITE = 2'h0;
    localparam logic [1:0] ALIAS_CLR   = 2'h1;
    localparam logic [1:0] ALIAS_SET   = 2'h2;
    localparam logic [1:0] ALIAS_INV   = 2'h3;

    // ------------------------------------------------------------
    // Register fields, masks and reset values
    // ------------------------------------------------------------
    localparam int          GC_ON_BIT       = 15;
    localparam int          GC_SUSPEND_BIT  = 12;
    localparam int          GC_BUSY_BIT     = 11;
    localparam logic [31:0] GC_WR_MASK      = 32'h0000_9000;
    localparam int          CON_BUSY_BIT    = 15;
    localparam int          CON_CHEN_BIT    = 7;
    localparam int          CON_AEN_BIT     = 4;
    localparam logic [31:0] CON_WR_MASK     = 32'h0000_01F7;
    localparam int          ECON_FORCE_BIT  = 7;
    localparam int          ECON_ABORT_BIT  = 6;
    localparam logic [31:0] ECON_WR_MASK    = 32'h00FF_FFF8;
    localparam logic [31:0] ECON_STORE_MASK = 32'h00FF_FF38;
    localparam logic [31:0] ECON_RESET      = 32'h00FF_FF00;
    localparam int          INT_CELL_BIT    = 2;
    localparam int          INT_BLOCK_BIT   = 3;
    localparam logic [31:0] INT_WR_MASK     = 32'h00FF_00FF;
    localparam logic [31:0] REG_RESET       = 32'h0000_0000;

    // Plain words: 0 ch2 pattern, 1 src start, 2 dst start, 3 src size,
    // 4 dst size, 5 cell size, 6 ch3 pattern
    localparam logic [PLAIN_N-1:0][15:0] PLAIN_OFF = {
        OFF_CH3_PATTERN, OFF_CH3_CELL_SIZE, OFF_CH3_DST_SIZE, OFF_CH3_SRC_SIZE,
        OFF_CH3_DST_START, OFF_CH3_SRC_START, OFF_CH2_PATTERN};
    localparam logic [PLAIN_N-1:0][31:0] PLAIN_MASK = {
        32'h0000_00FF, 32'h0000_FFFF, 32'h0000_FFFF, 32'h0000_FFFF,
        32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0000_00FF};

    // Register select codes
    localparam logic [3:0] SEL_GLOBAL = 4'h7;
    localparam logic [3:0] SEL_CON    = 4'h8;
    localparam logic [3:0] SEL_ECON   = 4'h9;
    localparam logic [3:0] SEL_INT    = 4'hA;
    localparam logic [3:0] SEL_SPTR   = 4'hB;
    localparam logic [3:0] SEL_DPTR   = 4'hC;
    localparam logic [3:0] SEL_CPTR3  = 4'hD;
    localparam logic [3:0] SEL_CPTR2  = 4'hE;
    localparam logic [3:0] SEL_NONE   = 4'hF;

    // In the clear, set and invert aliases zero bits of wdata leave the register alone; only masked bits move
    function automatic logic [31:0] alias_apply(input logic [31:0] old, input logic [31:0] wd,
                                                input logic [1:0] kind, input logic [31:0] mask);
        logic [31:0] v;
        v = wd;
        unique case (kind)
            ALIAS_WRITE: v = wd;
            ALIAS_CLR:   v = old & ~wd;
            ALIAS_SET:   v = old | wd;
            ALIAS_INV:   v = old ^ wd;
        endcase
        return (v & mask) | (old & ~mask);
    endfunction : alias_apply

endpackage : dmagc_pkg

// ===== hdl/dmagc_plain_regs.sv
// Plain read/write configuration words of the DMA channel register set
`timescale 1ns/1ns
module dmagc_plain_regs (
    // Clock and reset
    input  wire logic                                  pclk,
    input  wire logic                                  presetn,
    input  wire logic                                  ce,
    // Write port
    input  wire logic                                  wr_en,
    input  wire logic [2:0]                            wr_idx,
    input  wire logic [1:0]                            wr_kind,
    input  wire logic [31:0]                           wr_data,
    // Stored words
    output logic      [dmagc_pkg::PLAIN_N-1:0][31:0]   words
);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < dmagc_pkg::PLAIN_N; i++) begin
                words[i] <= dmagc_pkg::REG_RESET;
            end
        end else if (ce && wr_en) begin
            // Unimplemented bits never take a write
            words[wr_idx] <= dmagc_pkg::alias_apply(words[wr_idx], wr_data, wr_kind,
                                                    dmagc_pkg::PLAIN_MASK[wr_idx]);
        end
    end

endmodule : dmagc_plain_regs

// ===== hdl/dmagc_top.sv
// DMA global control and channel register set with a minimal channel 3 stepping engine
//
// Notes on behaviour
// - Each register has clear, set and invert aliases at +0x4, +0x8, +0xC.
// - Global enable bit 15 switches the whole DMA module on or off.
// - Suspend bit 12 stops all DMA transfers, leaving the data bus to the CPU.
// - Busy bit 11 reads one while active, zero when disabled and idle.
// - Unimplemented bits ignore writes and read as zero.
// - Reset clears every register; event control resets to 00FF_FF00.
//
// Register access over APB was decided locally.
`timescale 1ns/1ns
module dmagc_top (
    // Clock, reset and freeze
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Data bus side, same clock as the arbiter
    output logic             dma_bus_req,
    input  wire logic        bus_grant,
    output logic      [31:0] dma_src_addr,
    output logic      [31:0] dma_dst_addr,
    // Status
    output logic             module_active_flag
);

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic logic [3:0] reg_sel(input logic [15:0] a);
        logic [15:0] base;
        logic [3:0]  s;
        base = {a[15:4], 4'h0};
        s    = dmagc_pkg::SEL_NONE;
        for (int i = 0; i < dmagc_pkg::PLAIN_N; i++) begin
            if (base == dmagc_pkg::PLAIN_OFF[i]) begin
                s = 4'(i);
            end
        end
        unique case (base)
            dmagc_pkg::OFF_GLOBAL_CONTROL: s = dmagc_pkg::SEL_GLOBAL;
            dmagc_pkg::OFF_CH3_CONTROL:    s = dmagc_pkg::SEL_CON;
            dmagc_pkg::OFF_CH3_EVENT_CTRL: s = dmagc_pkg::SEL_ECON;
            dmagc_pkg::OFF_CH3_INT_CTRL:   s = dmagc_pkg::SEL_INT;
            dmagc_pkg::OFF_CH3_SRC_PTR:    s = dmagc_pkg::SEL_SPTR;
            dmagc_pkg::OFF_CH3_DST_PTR:    s = dmagc_pkg::SEL_DPTR;
            dmagc_pkg::OFF_CH3_CELL_PTR:   s = dmagc_pkg::SEL_CPTR3;
            dmagc_pkg::OFF_CH2_CELL_PTR:   s = dmagc_pkg::SEL_CPTR2;
            default: ;
        endcase
        return s;
    endfunction : reg_sel

    // Pointer step that wraps at the programmed size; size 0 means 65536
    function automatic logic [15:0] ptr_step(input logic [15:0] p, input logic [15:0] size);
        return (16'(p + 16'h0001) == size) ? 16'h0000 : 16'(p + 16'h0001);
    endfunction : ptr_step

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [3:0]                                 sel;
    logic [1:0]                                 kind;
    logic                                       wr;
    logic                                       setup;
    logic [dmagc_pkg::PLAIN_N-1:0][31:0]        words;
    logic                                       on_r;
    logic                                       suspend_r;
    logic [31:0]                                con_r;
    logic [31:0]                                econ_r;
    logic [31:0]                                int_r;
    logic [15:0]                                spt_r;
    logic [15:0]                                dpt_r;
    logic [15:0]                                cpt_r;
    logic                                       beat_act_r;
    logic [31:0]                                prdata_r;
    logic                                       err_r;
    logic [31:0]                                econ_wv;
    logic [31:0]                                glob_wv;
    logic                                       force_now;
    logic                                       abort_now;
    logic                                       run;
    logic                                       beat;
    logic                                       cell_done;
    logic                                       block_done;
    logic [31:0]                                glob_rd;
    logic [31:0]                                con_rd;
    logic [31:0]                                rd_val;

    assign sel   = reg_sel(paddr);
    assign kind  = paddr[3:2];
    assign setup = psel && !penable && ce;
    assign wr    = psel && penable && pwrite && ce && (sel != dmagc_pkg::SEL_NONE);

    // ------------------------------------------------------------
    // Plain configuration words
    // ------------------------------------------------------------
    dmagc_plain_regs u_plain (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .wr_en   (wr && (sel < 4'(dmagc_pkg::PLAIN_N))),
        .wr_idx  (sel[2:0]),
        .wr_kind (kind),
        .wr_data (pwdata),
        .words   (words)
    );

    // ------------------------------------------------------------
    // Global control
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            on_r      <= 1'b0;
            suspend_r <= 1'b0;
        end else if (ce && wr && sel == dmagc_pkg::SEL_GLOBAL) begin
            on_r      <= glob_wv[dmagc_pkg::GC_ON_BIT];
            suspend_r <= glob_wv[dmagc_pkg::GC_SUSPEND_BIT];
        end
    end

    // Busy and reserved bits fall outside the write mask, so they never store
    assign glob_wv = dmagc_pkg::alias_apply(glob_rd, pwdata, kind, dmagc_pkg::GC_WR_MASK);

    // Busy stays up for the beat in flight after enable drops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            beat_act_r <= 1'b0;
        end else if (ce) begin
            beat_act_r <= beat;
        end
    end

    assign module_active_flag = on_r || beat_act_r;

    always_comb begin
        glob_rd = '0;
        glob_rd[dmagc_pkg::GC_ON_BIT]      = on_r;
        glob_rd[dmagc_pkg::GC_SUSPEND_BIT] = suspend_r;
        glob_rd[dmagc_pkg::GC_BUSY_BIT]    = module_active_flag;
    end

    // ------------------------------------------------------------
    // Channel 3 event control
    // ------------------------------------------------------------
    // Force and abort are strobes: acted on, never stored
    assign econ_wv   = dmagc_pkg::alias_apply(econ_r, pwdata, kind, dmagc_pkg::ECON_WR_MASK);
    assign force_now = wr && sel == dmagc_pkg::SEL_ECON && econ_wv[dmagc_pkg::ECON_FORCE_BIT];
    assign abort_now = wr && sel == dmagc_pkg::SEL_ECON && econ_wv[dmagc_pkg::ECON_ABORT_BIT];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            econ_r <= dmagc_pkg::ECON_RESET;
        end else if (ce && wr && sel == dmagc_pkg::SEL_ECON) begin
            econ_r <= econ_wv & dmagc_pkg::ECON_STORE_MASK;
        end
    end

    // ------------------------------------------------------------
    // Channel 3 control
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            con_r <= dmagc_pkg::REG_RESET;
        end else if (ce) begin
            if (wr && sel == dmagc_pkg::SEL_CON) begin
                con_r <= dmagc_pkg::alias_apply(con_r, pwdata, kind, dmagc_pkg::CON_WR_MASK);
            end
            // Engine takes priority over a same-cycle software write
            if (abort_now || (block_done && !con_r[dmagc_pkg::CON_AEN_BIT])) begin
                con_r[dmagc_pkg::CON_CHEN_BIT] <= 1'b0;
            end else if (force_now) begin
                con_r[dmagc_pkg::CON_CHEN_BIT] <= 1'b1;
            end
        end
    end

    always_comb begin
        con_rd = con_r & dmagc_pkg::CON_WR_MASK;
        con_rd[dmagc_pkg::CON_BUSY_BIT] = run;
    end

    // ------------------------------------------------------------
    // Transfer stepping
    // ------------------------------------------------------------
    assign run         = on_r && !suspend_r && con_r[dmagc_pkg::CON_CHEN_BIT];
    assign dma_bus_req = run;
    assign beat        = run && bus_grant && ce && !abort_now;
    assign cell_done   = beat && ptr_step(cpt_r, words[5][15:0]) == 16'h0000;
    assign block_done  = beat && ptr_step(dpt_r, words[4][15:0]) == 16'h0000;

    // Pointers move only on a granted beat or an abort clear, so suspend resumes in place
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            spt_r <= '0;
            dpt_r <= '0;
            cpt_r <= '0;
        end else if (ce) begin
            if (abort_now) begin
                spt_r <= '0;
                dpt_r <= '0;
                cpt_r <= '0;
            end else if (beat) begin
                spt_r <= ptr_step(spt_r, words[3][15:0]);
                dpt_r <= ptr_step(dpt_r, words[4][15:0]);
                cpt_r <= ptr_step(cpt_r, words[5][15:0]);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dma_src_addr <= '0;
            dma_dst_addr <= '0;
        end else if (ce && beat) begin
            dma_src_addr <= words[1] + 32'(spt_r);
            dma_dst_addr <= words[2] + 32'(dpt_r);
        end
    end

    // ------------------------------------------------------------
    // Channel 3 interrupt flags and enables
    // ------------------------------------------------------------
    // A completion in the cycle of a clear keeps its flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_r <= dmagc_pkg::REG_RESET;
        end else if (ce) begin
            int_r <= ((wr && sel == dmagc_pkg::SEL_INT)
                      ? dmagc_pkg::alias_apply(int_r, pwdata, kind, dmagc_pkg::INT_WR_MASK)
                      : int_r)
                     | (32'(cell_done) << dmagc_pkg::INT_CELL_BIT)
                     | (32'(block_done) << dmagc_pkg::INT_BLOCK_BIT);
        end
    end

    // ------------------------------------------------------------
    // Read path, captured in the setup cycle
    // ------------------------------------------------------------
    always_comb begin
        rd_val = '0;
        unique case (sel)
            dmagc_pkg::SEL_GLOBAL: rd_val = glob_rd;
            dmagc_pkg::SEL_CON:    rd_val = con_rd;
            dmagc_pkg::SEL_ECON:   rd_val = econ_r;
            dmagc_pkg::SEL_INT:    rd_val = int_r;
            dmagc_pkg::SEL_SPTR:   rd_val = 32'(spt_r);
            dmagc_pkg::SEL_DPTR:   rd_val = 32'(dpt_r);
            dmagc_pkg::SEL_CPTR3:  rd_val = 32'(cpt_r);
            dmagc_pkg::SEL_CPTR2:  rd_val = '0;
            dmagc_pkg::SEL_NONE:   rd_val = '0;
            default:               rd_val = words[sel[2:0]];
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= '0;
            err_r    <= 1'b0;
        end else if (setup) begin
            prdata_r <= rd_val;
            err_r    <= sel == dmagc_pkg::SEL_NONE;
        end
    end

    // No wait states; a frozen block holds the access open
    assign prdata  = prdata_r;
    assign pready  = ce;
    assign pslverr = psel && penable && err_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking dcb @(posedge pclk); endclocking
    default disable iff (!presetn);

    alias_clear_a: assert property (
        (wr && ce && sel == dmagc_pkg::SEL_GLOBAL && kind == dmagc_pkg::ALIAS_CLR && pwdata[15])
        |=> !on_r)
        else $error("clear alias left enable set");

    enable_gate_a: assert property (!on_r |-> !dma_bus_req)
        else $error("bus request while disabled");

    suspend_hold_a: assert property (
        (ce && wr && sel == dmagc_pkg::SEL_GLOBAL && kind == dmagc_pkg::ALIAS_SET && pwdata[12])
        |=> !dma_bus_req [*2])
        else $error("transfer requested while suspended");

    busy_flag_a: assert property (
        (ce && !on_r && !beat) |=> (glob_rd[dmagc_pkg::GC_BUSY_BIT] == on_r))
        else $error("busy bit wrong when idle");

    reserved_zero_a: assert property (
        (psel && penable && sel == dmagc_pkg::SEL_GLOBAL) |-> (prdata & 32'hFFFF_67FF) == 32'h0000_0000)
        else $error("reserved control bits read nonzero");

    reset_value_a: assert property (
        $rose(presetn) |-> (econ_r == 32'h00FF_FF00 && int_r == 32'h0000_0000 && !on_r))
        else $error("register not at reset value");

    pointer_hold_a: assert property (
        (!run && !abort_now) |=> ($stable(spt_r) && $stable(dpt_r) && $stable(cpt_r)))
        else $error("pointer moved while halted");

    econ_reserved_a: assert property (
        (psel && penable && sel == dmagc_pkg::SEL_ECON) |-> (prdata & 32'hFF00_00C7) == 32'h0000_0000)
        else $error("event control reserved bits read nonzero");

    int_reserved_a: assert property (
        (psel && penable && sel == dmagc_pkg::SEL_INT) |-> (prdata & 32'hFF00_FF00) == 32'h0000_0000)
        else $error("interrupt reserved bits read nonzero");

    pattern_width_a: assert property (
        (psel && penable && sel == 4'h0) |-> prdata[31:8] == 24'h00_0000)
        else $error("pattern upper bits read nonzero");

    beat_busy_a: assert property (beat |=> module_active_flag)
        else $error("busy low after a beat");

endmodule : dmagc_top

// ===== verif/dmagc_bus_arbiter.sv
// Data bus arbiter model standing for the CPU side of the shared bus
`timescale 1ns/1ns
module dmagc_bus_arbiter (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Arbitration controls from the bench
    input  wire logic cpu_hold,
    input  wire logic slow,
    // Request and grant
    input  wire logic dma_bus_req,
    output logic      bus_grant
);
    logic alt_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alt_r <= 1'b0;
        end else begin
            alt_r <= ~alt_r;
        end
    end

    // CPU owns the bus while holding it; slow mode grants every other cycle
    assign bus_grant = dma_bus_req & ~cpu_hold & (~slow | alt_r);
endmodule : dmagc_bus_arbiter

// ===== verif/tb_dma_global_control_and_channel_regs.sv
// Self-checking bench for the DMA global control and channel register block
`timescale 1ns/1ns
module tb_dma_global_control_and_channel_regs;
    logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, dma_src_addr, dma_dst_addr, rd, save;
    logic        dma_bus_req, bus_grant, module_active_flag, cpu_hold, slow, err;
    int          err_total, tests_run;

    dmagc_top dmagc_top_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dma_bus_req(dma_bus_req), .bus_grant(bus_grant),
        .dma_src_addr(dma_src_addr), .dma_dst_addr(dma_dst_addr), .module_active_flag(module_active_flag));
    dmagc_bus_arbiter dmagc_bus_arbiter_i (.pclk(pclk), .presetn(presetn), .cpu_hold(cpu_hold),
        .slow(slow), .dma_bus_req(dma_bus_req), .bus_grant(bus_grant));

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
            err_total++;
        end
    endtask : chk

    // Holds the request until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            $display("mismatch at %0t: no pready", $time);
            err_total++;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp, input string msg);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, exp, msg);
    endtask : rd_chk

    task automatic give_verdict;
        $display("comparisons %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_reset;
        rd_chk(dmagc_pkg::OFF_GLOBAL_CONTROL, 32'h0000_0000, "global reset");
        rd_chk(dmagc_pkg::OFF_CH3_EVENT_CTRL, 32'h00FF_FF00, "event ctrl reset");
        rd_chk(dmagc_pkg::OFF_CH3_INT_CTRL, 32'h0000_0000, "int ctrl reset");
        rd_chk(dmagc_pkg::OFF_CH3_SRC_START, 32'h0000_0000, "src start reset");
        rd_chk(dmagc_pkg::OFF_CH3_CONTROL, 32'h0000_0000, "control reset");
        apb(1'b0, 16'h3400, 32'h0000_0000);
        chk({31'h0, err}, 32'h0000_0001, "unmapped error");
        $display("test reset done");
    endtask : test_reset

    task automatic test_global;
        apb(1'b1, dmagc_pkg::OFF_GLOBAL_CONTROL, 32'hFFFF_FFFF);
        rd_chk(dmagc_pkg::OFF_GLOBAL_CONTROL, 32'h0000_9800, "only on, suspend, busy");
        chk({31'h0, module_active_flag}, 32'h0000_0001, "flag while on");
        apb(1'b1, dmagc_pkg::OFF_GLOBAL_CONTROL + 16'h0004, 32'h0000_8000);
        repeat (2) @(posedge pclk);
        rd_chk(dmagc_pkg::OFF_GLOBAL_CONTROL, 32'h0000_1000, "clear alias");
        chk({31'h0, module_active_flag}, 32'h0000_0000, "flag when off");
        apb(1'b1, dmagc_pkg::OFF_GLOBAL_CONTROL + 16'h000C, 32'h0000_1000);
        rd_chk(dmagc_pkg::OFF_GLOBAL_CONTROL, 32'h0000_0000, "invert alias");
        apb(1'b1, dmagc_pkg::OFF_GLOBAL_CONTROL + 16'h0008, 32'h0000_8000);
        rd_chk(dmagc_pkg::OFF_GLOBAL_CONTROL, 32'h0000_8800, "set alias");
        $display("test global done");
    endtask : test_global

    task automatic test_beat;
        apb(1'b1, dmagc_pkg::OFF_CH3_SRC_START, 32'h0000_1000);
        apb(1'b1, dmagc_pkg::OFF_CH3_DST_START, 32'h0000_2000);
        apb(1'b1, dmagc_pkg::OFF_CH3_CONTROL + 16'h0008, 32'h0000_0090);
        #1 chk({31'h0, dma_bus_req}, 32'h0000_0001, "request when on");
        @(posedge pclk);
        cpu_hold <= 1'b0;
        @(posedge pclk);
        #1 chk(dma_src_addr, 32'h0000_1000, "first src addr");
        chk(dma_dst_addr, 32'h0000_2000, "first dst addr");
        $display("test beat done");
    endtask : test_beat

    task automatic test_suspend;
        logic [31:0] sp0;
        int          n;
        apb(1'b1, dmagc_pkg::OFF_GLOBAL_CONTROL + 16'h0008, 32'h0000_1000);
        #1 chk({31'h0, dma_bus_req}, 32'h0000_0000, "no request suspended");
        save = dma_src_addr;
        apb(1'b0, dmagc_pkg::OFF_CH3_SRC_PTR, 32'h0000_0000);
        sp0 = rd;
        repeat (5) @(posedge pclk);
        #1 chk(dma_src_addr, save, "addr frozen");
        rd_chk(dmagc_pkg::OFF_CH3_SRC_PTR, sp0, "pointer frozen");
        slow <= 1'b1;
        apb(1'b1, dmagc_pkg::OFF_GLOBAL_CONTROL + 16'h0004, 32'h0000_1000);
        n = 0;
        while (dma_src_addr === save && n < 4) begin
            @(posedge pclk);
            #1;
            n++;
        end
        #1 chk({31'h0, dma_src_addr !== save}, 32'h0000_0001, "resumed");
        chk(dma_src_addr, 32'h0000_1000 + sp0, "resume point");
        apb(1'b1, dmagc_pkg::OFF_GLOBAL_CONTROL + 16'h0004, 32'h0000_8000);
        #1 chk({31'h0, dma_bus_req}, 32'h0000_0000, "no request off");
        repeat (2) @(posedge pclk);
        #1 chk({31'h0, module_active_flag}, 32'h0000_0000, "idle flag");
        rd_chk(dmagc_pkg::OFF_GLOBAL_CONTROL, 32'h0000_0000, "busy clear");
        $display("test suspend done");
    endtask : test_suspend

    task automatic test_rereset;
        apb(1'b1, dmagc_pkg::OFF_CH2_PATTERN, 32'hFFFF_FFFF);
        rd_chk(dmagc_pkg::OFF_CH2_PATTERN, 32'h0000_00FF, "pattern width");
        apb(1'b1, dmagc_pkg::OFF_CH3_EVENT_CTRL, 32'hFF12_3487);
        rd_chk(dmagc_pkg::OFF_CH3_EVENT_CTRL, 32'h0012_3400, "event ctrl bits");
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(dmagc_pkg::OFF_CH3_EVENT_CTRL, 32'h00FF_FF00, "event ctrl rereset");
        rd_chk(dmagc_pkg::OFF_CH2_PATTERN, 32'h0000_0000, "pattern rereset");
        rd_chk(dmagc_pkg::OFF_CH3_SRC_PTR, 32'h0000_0000, "src ptr rereset");
        rd_chk(dmagc_pkg::OFF_CH3_CONTROL, 32'h0000_0000, "control rereset");
        $display("test rereset done");
    endtask : test_rereset

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        presetn = 1'b0; ce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 16'h0000; pwdata = 32'h0000_0000; cpu_hold = 1'b1; slow = 1'b0;
        err_total = 0;
        tests_run = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        test_reset();
        test_global();
        test_beat();
        test_suspend();
        test_rereset();
        give_verdict();
    end

    // Tests need about 125 cycles; this leaves wide margin
    initial begin
        repeat (5000) @(posedge pclk);
        err_total++;
        give_verdict();
    end
endmodule : tb_dma_global_control_and_channel_regs
